// ---- inc/bssp_pkg.sv ----
// =====================================================================
// Shared constants for the two-word burst synchronous SRAM port
package bssp_pkg;

  // =====================================================================
  // Organisation
  localparam int BYTE_W = 9;
  localparam int DEF_DQ_W = 36;
  localparam int DEF_ADDR_W = 20;
  localparam int DEF_IMP_W = 6;
  localparam int BURST_LEN = 2;

  // =====================================================================
  // System clock
  localparam int CLK_PERIOD_NS = 50;

  // =====================================================================
  // Link clock generation, in system clock phases per link period; read-to-write gap in link periods
  localparam int KDIV = 8;
  localparam int K_HALF = KDIV / 2;
  localparam int PH_W = 3;
  localparam int CMD_PH = 1;
  localparam int WR_BEAT1_PH = K_HALF + 1;
  localparam int RD_WR_GAP = 3;
  localparam int GAP_W = 2;

  // =====================================================================
  // Timing counts
  localparam int IMP_PERIOD_US = 20;
  localparam int IMP_CYCLES = (IMP_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int IMP_CNT_W = $clog2(IMP_CYCLES);
  localparam int LOCK_TIME_US = 20;
  localparam int LOCK_CYCLES = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CNT_W = $clog2(LOCK_CYCLES + 1);

  // =====================================================================
  // Synchroniser field positions of the link clocks and controls
  localparam int POS_K = 0;
  localparam int POS_KN = 1;
  localparam int POS_C = 2;
  localparam int POS_CN = 3;
  localparam int POS_LD = 4;
  localparam int POS_RW = 5;
  localparam int POS_BP = 6;
  localparam int POS_ADDR = 7;

endpackage

// ---- inc/bssp_link_if.sv ----
`timescale 1ns/1ps
// =====================================================================
// Pin bundle between memory controller and burst SRAM port
interface bssp_link_if #(
  parameter int DQ_W = 36,
  parameter int ADDR_W = 20,
  parameter int IMP_W = 6
);
  logic k;
  logic k_n;
  logic c;
  logic c_n;
  logic load_strobe_n;
  logic rw;
  logic pll_bypass_n;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W/9-1:0] byte_write_n;
  logic [DQ_W-1:0] dq_host;
  logic dq_host_oe;
  logic [DQ_W-1:0] dq_dev;
  logic dq_dev_oe;
  logic [DQ_W-1:0] dq_bus;
  logic echo_strobe;
  logic echo_strobe_n;
  logic [IMP_W-1:0] impedance_ref;

  // Resolved level of the common data wires
  assign dq_bus = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : '0);

  modport host (
    output k, k_n, c, c_n, load_strobe_n, rw, pll_bypass_n, addr, byte_write_n,
    output dq_host, dq_host_oe,
    input dq_bus, echo_strobe, echo_strobe_n
  );

  modport dev (
    input k, k_n, c, c_n, load_strobe_n, rw, pll_bypass_n, addr, byte_write_n,
    input dq_bus, impedance_ref,
    output dq_dev, dq_dev_oe, echo_strobe, echo_strobe_n
  );
endinterface

// ---- core/bssp_dev.sv ----
`timescale 1ns/1ps
// Behaviour
// [R1] Loaded cycle: direction high reads, low writes
// [R2] Direction sampled only at true input clock rise
// [R3] Only bytes with low strobe get stored
// [R4] Strobes sampled per beat, K then K#
// [R5] One strobe per nine data bits
// [R6] Controls on K rise, data on both rises
// [R7] Controller drives K# half period from K
// [R8] Read beat one on C#, two on C
// [R9] Output clocks both high: time from K pair
// [R10] Echo clocks follow data, run while tristated
// [R11] Echo stops when its source clock stops
// [R12] Output impedance refreshed every fixed interval
// [R13] Bypass low: run without PLL lock wait
// [R14] Keep bypass high for normal operation
// [R15] Load low starts burst; high is no-op
// [R16] Burst starts at given bit, then inverted
// [R17] Read beats at C#(t+1) and C(t+2)
// [R18] Write beats at K(t+1) and K#(t+1)
// [R19] Data pins released outside read beats
module bssp_dev
  import bssp_pkg::*;
#(
  parameter int DQ_W = DEF_DQ_W,
  parameter int ADDR_W = DEF_ADDR_W,
  parameter int IMP_W = DEF_IMP_W
)
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  bssp_link_if.dev link,
  output logic ready_o,
  output logic single_clk_o,
  output logic [IMP_W-1:0] imp_code_o,
  output logic imp_update_o
);

  localparam int BW_W = DQ_W / BYTE_W;
  localparam int POS_BW = POS_ADDR + ADDR_W;
  localparam int POS_DQ = POS_BW + BW_W;
  localparam int POS_IMP = POS_DQ + DQ_W;
  localparam int SW = POS_IMP + IMP_W;
  localparam logic [ADDR_W-1:0] BURST_FLIP = {{(ADDR_W-1){1'h0}}, 1'h1};

  // =====================================================================
  // Elaboration checks
  if (!(DQ_W == BYTE_W || DQ_W == 2 * BYTE_W || DQ_W == 4 * BYTE_W))
  begin : g_bad_width
    $error("bssp_dev: data width must be 9, 18 or 36");
  end
  if (ADDR_W < 2 || IMP_W < 1)
  begin : g_bad_addr
    $error("bssp_dev: address or impedance width too small");
  end

  // =====================================================================
  // Merge of one data beat under its byte strobes
  function automatic logic [DQ_W-1:0] bssp_merge(
    input logic [DQ_W-1:0] old_w,
    input logic [DQ_W-1:0] new_w,
    input logic [BW_W-1:0] bw_n
  );
    logic [DQ_W-1:0] res;
    res = old_w;
    for (int b = 0; b < BW_W; b++)
    begin
      if (!bw_n[b]) // [R3] [R5]
      begin
        res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  // =====================================================================
  // Three-stage synchroniser on every link input
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;

  assign raw = {link.impedance_ref, link.dq_bus, link.byte_write_n, link.addr, link.pll_bypass_n,
                link.rw, link.load_strobe_n, link.c_n, link.c, link.k_n, link.k};

  // Pin samples move one stage each rising edge
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // =====================================================================
  // Clock levels and rising edges, once two stages agree
  logic [3:0] lvl_q;
  logic [3:0] lvl_d;
  logic [3:0] rise;
  logic [3:0] agree;
  logic single;
  logic ref_t_rise;
  logic ref_c_rise;

  assign agree = ~(s2_q[POS_CN:POS_K] ^ s3_q[POS_CN:POS_K]);
  assign lvl_d = (lvl_q & ~agree) | (s3_q[POS_CN:POS_K] & agree);
  assign rise = lvl_d & ~lvl_q;
  // Both output clocks held high selects the input pair as timing source
  assign single = lvl_q[POS_C] & lvl_q[POS_CN]; // [R9]
  assign ref_t_rise = single ? rise[POS_K] : rise[POS_C]; // [R9]
  assign ref_c_rise = single ? rise[POS_KN] : rise[POS_CN]; // [R9]

  // Agreed clock levels
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      lvl_q <= 4'h0;
    end
    else
    begin
      lvl_q <= lvl_d;
    end
  end

  // Synchronised control and data fields
  logic ld_n;
  logic rd_dir;
  logic bypass_n;
  logic [ADDR_W-1:0] cmd_addr;
  logic [BW_W-1:0] bw_n;
  logic [DQ_W-1:0] wr_beat;
  logic [IMP_W-1:0] imp_ref;

  assign ld_n = s3_q[POS_LD];
  assign rd_dir = s3_q[POS_RW];
  assign bypass_n = s3_q[POS_BP];
  assign cmd_addr = s3_q[POS_ADDR +: ADDR_W];
  assign bw_n = s3_q[POS_BW +: BW_W];
  assign wr_beat = s3_q[POS_DQ +: DQ_W];
  assign imp_ref = s3_q[POS_IMP +: IMP_W];

  // =====================================================================
  // PLL lock wait, skipped when the bypass input is low
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic ready_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      lock_cnt_q <= '0;
      ready_q <= 1'h0;
    end
    else if (!bypass_n)
    begin
      lock_cnt_q <= '0;
      ready_q <= 1'h1; // [R13]
    end
    else if (lock_cnt_q != LOCK_CNT_W'(LOCK_CYCLES))
    begin
      lock_cnt_q <= lock_cnt_q + LOCK_CNT_W'(1); // [R14]
      ready_q <= 1'h0;
    end
    else
    begin
      ready_q <= 1'h1;
    end
  end

  // =====================================================================
  // Command capture and burst pipeline, advanced by true input clock rises
  logic cmd;
  logic wcap_q;
  logic rcap_q;
  logic [ADDR_W-1:0] cap_addr_q;
  logic w2_q;
  logic [ADDR_W-1:0] w2_addr_q;
  logic rarm_q;
  logic [ADDR_W-1:0] rarm_addr_q;

  // Load low starts a burst; high leaves the cycle as no-op
  assign cmd = ready_q & ~ld_n; // [R15]

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      wcap_q <= 1'h0;
      rcap_q <= 1'h0;
      cap_addr_q <= '0;
      w2_q <= 1'h0;
      w2_addr_q <= '0;
      rarm_q <= 1'h0;
      rarm_addr_q <= '0;
    end
    else if (rise[POS_K]) // [R2] [R6]
    begin
      wcap_q <= cmd & ~rd_dir; // [R1]
      rcap_q <= cmd & rd_dir; // [R1]
      if (cmd)
      begin
        cap_addr_q <= cmd_addr; // [R15]
      end
      w2_q <= wcap_q; // [R18]
      w2_addr_q <= cap_addr_q ^ BURST_FLIP; // [R16]
      rarm_q <= rcap_q; // [R17]
      rarm_addr_q <= cap_addr_q;
    end
  end

  // =====================================================================
  // Storage array, written beat by beat under byte strobes
  logic [DQ_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_sys_i)
  begin
    if (rise[POS_K] && wcap_q)
    begin
      mem[cap_addr_q] <= bssp_merge(mem[cap_addr_q], wr_beat, bw_n); // [R4] [R6] [R18]
    end
    else if (rise[POS_KN] && w2_q)
    begin
      mem[w2_addr_q] <= bssp_merge(mem[w2_addr_q], wr_beat, bw_n); // [R4] [R6] [R18]
    end
  end

  // =====================================================================
  // Read launch on the selected clock pair, with echo clocks beside it
  logic [DQ_W-1:0] dq_q;
  logic oe_q;
  logic rb2_q;
  logic [ADDR_W-1:0] rd2_addr_q;
  logic echo_q;
  logic echo_n_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      dq_q <= '0;
      oe_q <= 1'h0;
      rb2_q <= 1'h0;
      rd2_addr_q <= '0;
    end
    else if (ref_c_rise)
    begin
      oe_q <= rarm_q; // [R19]
      rb2_q <= rarm_q;
      rd2_addr_q <= rarm_addr_q ^ BURST_FLIP; // [R16]
      if (rarm_q)
      begin
        dq_q <= mem[rarm_addr_q]; // [R8] [R17]
      end
    end
    else if (ref_t_rise && rb2_q)
    begin
      dq_q <= mem[rd2_addr_q]; // [R8] [R17]
      rb2_q <= 1'h0;
    end
  end

  // Echo clocks copy the timing source, so they stop when it stops
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      echo_q <= 1'h0;
      echo_n_q <= 1'h0;
    end
    else
    begin
      echo_q <= single ? lvl_d[POS_K] : lvl_d[POS_C]; // [R10] [R11]
      echo_n_q <= single ? lvl_d[POS_KN] : lvl_d[POS_CN]; // [R10] [R11]
    end
  end

  // =====================================================================
  // Periodic output impedance refresh
  logic [IMP_CNT_W-1:0] imp_cnt_q;
  logic [IMP_W-1:0] imp_code_q;
  logic imp_update_q;
  logic single_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      imp_cnt_q <= '0;
      imp_code_q <= '0;
      imp_update_q <= 1'h0;
    end
    else if (imp_cnt_q == IMP_CNT_W'(IMP_CYCLES - 1))
    begin
      imp_cnt_q <= '0;
      imp_code_q <= imp_ref; // [R12]
      imp_update_q <= 1'h1; // [R12]
    end
    else
    begin
      imp_cnt_q <= imp_cnt_q + IMP_CNT_W'(1);
      imp_update_q <= 1'h0;
    end
  end

  // Timing source status
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      single_q <= 1'h0;
    end
    else
    begin
      single_q <= single;
    end
  end

  // =====================================================================
  // Outputs
  assign link.dq_dev = dq_q;
  assign link.dq_dev_oe = oe_q;
  assign link.echo_strobe = echo_q;
  assign link.echo_strobe_n = echo_n_q;
  assign ready_o = ready_q;
  assign single_clk_o = single_q;
  assign imp_code_o = imp_code_q;
  assign imp_update_o = imp_update_q;

endmodule

// ---- core/bssp_host.sv ----
`timescale 1ns/1ps
// =====================================================================
// Memory controller end: makes the link clocks and runs two-beat bursts
module bssp_host
  import bssp_pkg::*;
#(
  parameter int DQ_W = DEF_DQ_W,
  parameter int ADDR_W = DEF_ADDR_W
)
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  bssp_link_if.host link,
  input wire logic single_clk_i,
  input wire logic pll_bypass_n_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DQ_W-1:0] wr_data0_i,
  input wire logic [DQ_W-1:0] wr_data1_i,
  input wire logic [DQ_W/9-1:0] wr_be0_i,
  input wire logic [DQ_W/9-1:0] wr_be1_i,
  output logic rd_ready_o,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [DQ_W-1:0] rd_data0_o,
  output logic [DQ_W-1:0] rd_data1_o
);

  localparam int BW_W = DQ_W / BYTE_W;
  localparam int HW = DQ_W + 2;

  // =====================================================================
  // Elaboration checks
  if (!(DQ_W == BYTE_W || DQ_W == 2 * BYTE_W || DQ_W == 4 * BYTE_W))
  begin : g_bad_width
    $error("bssp_host: data width must be 9, 18 or 36");
  end

  // =====================================================================
  // Phase counter and link clocks
  logic [PH_W-1:0] ph_q;
  logic k_q;
  logic k_n_q;
  logic c_q;
  logic c_n_q;
  logic k_d;
  logic bypass_n_q;

  always_comb
  begin
    k_d = k_q;
    if (ph_q == PH_W'(K_HALF - 1))
    begin
      k_d = 1'h0;
    end
    else if (ph_q == PH_W'(KDIV - 1))
    begin
      k_d = 1'h1;
    end
  end

  // Complement clock is the exact inverse, half a period away
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      ph_q <= '0;
      k_q <= 1'h0;
      k_n_q <= 1'h1;
      c_q <= 1'h0;
      c_n_q <= 1'h1;
      bypass_n_q <= 1'h1;
    end
    else
    begin
      ph_q <= ph_q + PH_W'(1);
      k_q <= k_d;
      k_n_q <= ~k_d; // [R7]
      c_q <= single_clk_i | k_d; // [R9]
      c_n_q <= single_clk_i | ~k_d; // [R9]
      bypass_n_q <= pll_bypass_n_i; // [R14]
    end
  end

  // =====================================================================
  // Request acceptance; writes wait out the bus turnaround after a read
  logic rd_ready_q;
  logic wr_ready_q;
  logic [GAP_W-1:0] gap_q;
  logic take;
  logic take_rd;

  assign take = req_valid_i && (req_write_i ? wr_ready_q : rd_ready_q);
  assign take_rd = take && !req_write_i;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      rd_ready_q <= 1'h0;
      wr_ready_q <= 1'h0;
      gap_q <= '0;
    end
    else
    begin
      rd_ready_q <= (ph_q == PH_W'(CMD_PH - 1));
      wr_ready_q <= (ph_q == PH_W'(CMD_PH - 1)) && (gap_q <= GAP_W'(1));
      if (take_rd)
      begin
        gap_q <= GAP_W'(RD_WR_GAP);
      end
      else if (ph_q == PH_W'(CMD_PH - 1) && gap_q != '0)
      begin
        gap_q <= gap_q - GAP_W'(1);
      end
    end
  end

  // =====================================================================
  // Command pins and write beats
  logic ld_n_q;
  logic rw_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DQ_W-1:0] w0_q;
  logic [DQ_W-1:0] w1_q;
  logic [BW_W-1:0] be0_q;
  logic [BW_W-1:0] be1_q;
  logic wload_q;
  logic wb2_q;
  logic wload2_q;
  logic [DQ_W-1:0] wd0_q;
  logic [DQ_W-1:0] wd1_q;
  logic [BW_W-1:0] wbe0_q;
  logic [BW_W-1:0] wbe1_q;
  logic [DQ_W-1:0] dq_q;
  logic [BW_W-1:0] bw_n_q;
  logic oe_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      ld_n_q <= 1'h1;
      rw_q <= 1'h1;
      addr_q <= '0;
      w0_q <= '0;
      w1_q <= '0;
      be0_q <= '0;
      be1_q <= '0;
      wload_q <= 1'h0;
      wb2_q <= 1'h0;
      wload2_q <= 1'h0;
      wd0_q <= '0;
      wd1_q <= '0;
      wbe0_q <= '0;
      wbe1_q <= '0;
      dq_q <= '0;
      bw_n_q <= '1;
      oe_q <= 1'h0;
    end
    else if (ph_q == PH_W'(CMD_PH))
    begin
      ld_n_q <= ~take; // [R15]
      wload_q <= take && req_write_i;
      if (take)
      begin
        rw_q <= ~req_write_i; // [R1] [R2]
        addr_q <= req_addr_i;
        w0_q <= wr_data0_i;
        w1_q <= wr_data1_i;
        be0_q <= wr_be0_i;
        be1_q <= wr_be1_i;
      end
      // Beats wait one link period, since the device takes them at K(t+1)
      wload2_q <= wload_q; // [R18]
      wd0_q <= w0_q;
      wd1_q <= w1_q;
      wbe0_q <= be0_q;
      wbe1_q <= be1_q;
      if (wb2_q)
      begin
        dq_q <= wd1_q; // [R18]
        bw_n_q <= ~wbe1_q; // [R4]
      end
    end
    else if (ph_q == PH_W'(WR_BEAT1_PH))
    begin
      wb2_q <= wload2_q;
      oe_q <= wload2_q;
      dq_q <= wd0_q; // [R18]
      bw_n_q <= wload2_q ? ~wbe0_q : '1; // [R3] [R4]
    end
  end

  // =====================================================================
  // Three-stage synchroniser on echo clocks and data wires
  logic [HW-1:0] h1_q;
  logic [HW-1:0] h2_q;
  logic [HW-1:0] h3_q;
  logic [1:0] elvl_q;
  logic [1:0] elvl_d;
  logic [1:0] erise;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      h1_q <= '0;
      h2_q <= '0;
      h3_q <= '0;
      elvl_q <= 2'h0;
    end
    else
    begin
      h1_q <= {link.dq_bus, link.echo_strobe_n, link.echo_strobe};
      h2_q <= h1_q;
      h3_q <= h2_q;
      elvl_q <= elvl_d;
    end
  end

  assign elvl_d = (elvl_q & (h2_q[1:0] ^ h3_q[1:0])) | (h3_q[1:0] & ~(h2_q[1:0] ^ h3_q[1:0]));
  assign erise = elvl_d & ~elvl_q;

  // =====================================================================
  // Read capture: beat one on echo complement rise, beat two on echo true rise
  logic rtaken_q;
  logic [2:0] rpipe_q;
  logic got1_q;
  logic [DQ_W-1:0] d0_q;
  logic rd_valid_q;
  logic [DQ_W-1:0] rd0_q;
  logic [DQ_W-1:0] rd1_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      rtaken_q <= 1'h0;
      rpipe_q <= 3'h0;
      got1_q <= 1'h0;
      d0_q <= '0;
      rd_valid_q <= 1'h0;
      rd0_q <= '0;
      rd1_q <= '0;
    end
    else
    begin
      rd_valid_q <= 1'h0;
      if (ph_q == PH_W'(CMD_PH))
      begin
        rtaken_q <= take_rd;
      end
      if (ph_q == PH_W'(KDIV - 1))
      begin
        rpipe_q <= {rpipe_q[1:0], rtaken_q};
      end
      // Window covers the echo complement rise of C#(t+1) after synchronising
      if (erise[1] && rpipe_q[2])
      begin
        d0_q <= h3_q[HW-1:2]; // [R8] [R17]
        got1_q <= 1'h1;
      end
      else if (erise[0] && got1_q)
      begin
        rd0_q <= d0_q;
        rd1_q <= h3_q[HW-1:2]; // [R8] [R17]
        rd_valid_q <= 1'h1;
        got1_q <= 1'h0;
      end
    end
  end

  // =====================================================================
  // Outputs
  assign link.k = k_q;
  assign link.k_n = k_n_q;
  assign link.c = c_q;
  assign link.c_n = c_n_q;
  assign link.load_strobe_n = ld_n_q;
  assign link.rw = rw_q;
  assign link.pll_bypass_n = bypass_n_q;
  assign link.addr = addr_q;
  assign link.byte_write_n = bw_n_q;
  assign link.dq_host = dq_q;
  assign link.dq_host_oe = oe_q;
  assign rd_ready_o = rd_ready_q;
  assign wr_ready_o = wr_ready_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_data0_o = rd0_q;
  assign rd_data1_o = rd1_q;

endmodule

// ---- dv/bssp_link_checker.sv ----
`timescale 1ns/1ps
// =====================================================================
// Link timing checks between controller and memory ends
module bssp_link_checker
#(
  parameter int DQ_W = 36
)
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic load_strobe_n,
  input wire logic rw,
  input wire logic [DQ_W/9-1:0] byte_write_n,
  input wire logic [DQ_W-1:0] dq_host,
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe,
  input wire logic echo_strobe,
  input wire logic echo_strobe_n
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  // =====================================================================
  // Host side
  a_k_half_period: assert property ($rose(k) |-> k[*4] ##1 !k[*4])
    else $error("input clock duty wrong");
  a_ctrl_at_k: assert property ($rose(k) |-> $stable(load_strobe_n) && $stable(rw))
    else $error("controls moved at clock rise");
  a_bw_beat_hold: assert property (($rose(k) || $rose(k_n)) && dq_host_oe |-> $stable(byte_write_n) && $stable(dq_host))
    else $error("beat moved at capture edge");
  a_write_beat_lat: assert property ($fell(load_strobe_n) && !rw |-> ##[11:13] $rose(dq_host_oe))
    else $error("write data late");

  // =====================================================================
  // Device side
  a_no_contention: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("both ends drive data");
  a_beat1_echo: assert property ($rose(dq_dev_oe) |-> $rose(echo_strobe_n))
    else $error("first beat not on echo complement");
  a_beat2_echo: assert property ($rose(dq_dev_oe) |-> ##[3:5] (dq_dev_oe && $rose(echo_strobe)))
    else $error("second beat missing");
  a_read_lat: assert property ($fell(load_strobe_n) && rw |-> ##[21:23] (dq_dev_oe && $rose(echo_strobe_n)))
    else $error("read data late");
  a_echo_follow: assert property ($rose(c) |-> ##[1:6] $rose(echo_strobe))
    else $error("echo not following output clock");
  a_echo_single: assert property ((c && c_n)[*8] ##0 $rose(k) |-> ##[1:6] $rose(echo_strobe))
    else $error("echo not following input clock");
  a_nop_quiet: assert property (load_strobe_n[*8] ##1 load_strobe_n[*8] ##1 load_strobe_n[*7] |-> !dq_dev_oe)
    else $error("data driven without load");
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import bssp_pkg::*;
;
  logic clk_sys_i;
  logic rst_b_i;
  logic single_clk_i;
  logic pll_bypass_n_i;
  logic req_valid_i;
  logic req_write_i;
  logic [5:0] req_addr_i;
  logic [35:0] wr_data0_i;
  logic [35:0] wr_data1_i;
  logic [3:0] wr_be0_i;
  logic [3:0] wr_be1_i;
  logic rd_ready_o;
  logic wr_ready_o;
  logic rd_valid_o;
  logic [35:0] rd_data0_o;
  logic [35:0] rd_data1_o;
  logic ready_o;
  logic single_clk_o;
  logic [5:0] imp_code_o;
  logic imp_update_o;
  logic [35:0] mem [64];
  int bad_count;
  int comparisons;

  bssp_link_if #(.ADDR_W(6)) link ();

  bssp_host #(.ADDR_W(6)) u_bssp_host (.clk_sys_i, .rst_b_i, .link, .single_clk_i, .pll_bypass_n_i,
    .req_valid_i, .req_write_i, .req_addr_i, .wr_data0_i, .wr_data1_i, .wr_be0_i, .wr_be1_i,
    .rd_ready_o, .wr_ready_o, .rd_valid_o, .rd_data0_o, .rd_data1_o);

  bssp_dev #(.ADDR_W(6)) u_bssp_dev (.clk_sys_i, .rst_b_i, .link, .ready_o,
    .single_clk_o, .imp_code_o, .imp_update_o);

  bssp_link_checker u_bssp_link_checker (.clk_sys_i, .rst_b_i, .k(link.k), .k_n(link.k_n),
    .c(link.c), .c_n(link.c_n), .load_strobe_n(link.load_strobe_n), .rw(link.rw),
    .byte_write_n(link.byte_write_n), .dq_host(link.dq_host), .dq_host_oe(link.dq_host_oe),
    .dq_dev_oe(link.dq_dev_oe), .echo_strobe(link.echo_strobe), .echo_strobe_n(link.echo_strobe_n));

  // System clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;
  end

  // =====================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Wait for the matching ready pulse, present one request, update the model
  task automatic issue(input logic wr, input logic [5:0] a, input logic [35:0] d0, input logic [35:0] d1,
                       input logic [3:0] e0, input logic [3:0] e1);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while ((wr ? wr_ready_o : rd_ready_o) !== 1'b1 && n < 64)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("req_ready", 36'h1, {35'h0, wr ? wr_ready_o : rd_ready_o});
    {req_write_i, req_addr_i, wr_data0_i, wr_data1_i, wr_be0_i, wr_be1_i} = {wr, a, d0, d1, e0, e1};
    req_valid_i = 1'b1;
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      if (wr && e0[b])
        mem[a][9*b +: 9] = d0[9*b +: 9];
      if (wr && e1[b])
        mem[a ^ 6'h01][9*b +: 9] = d1[9*b +: 9];
    end
  endtask

  // Read one burst and compare both beats with the model
  task automatic rd(input logic [5:0] a);
    int n;
    n = 0;
    issue(1'b0, a, 36'h0, 36'h0, 4'h0, 4'h0);
    while (rd_valid_o !== 1'b1 && n < 64)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("rd_valid_o", 36'h1, {35'h0, rd_valid_o});
    chk("rd_data0_o", mem[a], rd_data0_o);
    chk("rd_data1_o", mem[a ^ 6'h01], rd_data1_o);
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_bypass();
    repeat (12) @(negedge clk_sys_i);
    chk("ready_o", 36'h1, {35'h0, ready_o});
    pll_bypass_n_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    chk("ready_o", 36'h0, {35'h0, ready_o});
    repeat (LOCK_CYCLES) @(negedge clk_sys_i);
    chk("ready_o", 36'h1, {35'h0, ready_o});
  endtask

  task automatic t_burst();
    issue(1'b1, 6'h04, 36'h123456789, 36'hABCDEF012, 4'hF, 4'hF);
    issue(1'b1, 6'h0B, 36'h0F0F0F0F0, 36'hF0F0F0F0F, 4'hF, 4'hF);
    rd(6'h04);
    rd(6'h05);
    rd(6'h0A);
  endtask

  task automatic t_bytes();
    for (int b = 0; b < 4; b++)
    begin
      issue(1'b1, 6'h04, 36'hFEDCBA987 - 36'(b), 36'h13579BDF0 + 36'(b), 4'(1 << b), 4'(~(1 << b)));
      rd(6'h04);
    end
  endtask

  task automatic t_single();
    single_clk_i = 1'b1;
    repeat (24) @(negedge clk_sys_i);
    chk("single_clk_o", 36'h1, {35'h0, single_clk_o});
    rd(6'h04);
    single_clk_i = 1'b0;
    repeat (24) @(negedge clk_sys_i);
    chk("single_clk_o", 36'h0, {35'h0, single_clk_o});
    rd(6'h0A);
  endtask

  task automatic t_imp();
    int n;
    n = 0;
    while (imp_update_o !== 1'b1 && n < 500)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("imp_code_o", 36'h2A, {30'h0, imp_code_o});
    link.impedance_ref = 6'h15;
    n = 0;
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (imp_update_o !== 1'b1 && n < 500);
    chk("imp_period", 36'(IMP_CYCLES), 36'(n));
    chk("imp_code_o", 36'h15, {30'h0, imp_code_o});
  endtask

  // Reset, then run every scenario
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    rst_b_i = 1'b0;
    single_clk_i = 1'b0;
    pll_bypass_n_i = 1'b0;
    req_valid_i = 1'b0;
    {req_write_i, req_addr_i, wr_data0_i, wr_data1_i, wr_be0_i, wr_be1_i} = '0;
    link.impedance_ref = 6'h2A;
    repeat (2) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    t_bypass();
    t_burst();
    t_bytes();
    t_single();
    t_imp();
    end_of_test();
  end

  // Cut a hang short well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    end_of_test();
  end
endmodule
